// ==== qpa_arbiter.sv ====
/*
 * Quad-port DRAM arbiter with access sequencer: round-robin arbiter
 * over four ports with locking, and a DRAM sequencer that interleaves
 * port accesses, 3-clock burst beats and refresh.
 * Assumes port inputs synchronous to clk and a page-mode DRAM whose
 * row and column share the multiplexed address pins.
 * Refresh is served before waiting ports; a port access waits out
 * precharge in the sequencer, never in the arbiter.
 */
// Operation
// RQ1 - four ports served in circular round-robin
// RQ2 - served port drops to lowest priority
// RQ3 - port lock keeps memory ownership
// RQ4 - requests sampled only in four idle states
// RQ5 - unlocked: pick highest pending, request memory
// RQ6 - grant asserted entering port-active state
// RQ7 - grant enables port buses onto memory
// RQ8 - stay active until sequencer reports completion
// RQ9 - completion returns to served port's idle
// RQ10 - new request immediately; start after precharge
// RQ11 - sequencer arbitrates memory versus refresh requests
// RQ12 - sequencer drives mux select, gated strobes
// RQ13 - ready whenever valid data on bus
// RQ14 - burst: 3-clock beats while burst held
// RQ15 - burst end or single: precharge, done
// RQ16 - four requests resolved in one cycle
// RQ17 - 32-bit shared data path, full-width bursts
// RQ18 - locked: only locking port granted
// RQ19 - reset: idle, no grants, strobes inactive
`timescale 1ns/1ns
`include "qpa_consts.svh"

module qpa_arbiter #(
	parameter int PORTS  = `QPA_PORTS,
	parameter int DATA_W = `QPA_DATA_W,
	parameter int ADDR_W = `QPA_ADDR_W,
	parameter int BE_W   = `QPA_BE_W
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// port requests
	input  wire logic [PORTS-1:0]        port_req,
	input  wire logic [PORTS-1:0]        port_lock,
	input  wire logic [PORTS-1:0]        port_burst,
	input  wire logic [PORTS-1:0]        port_we,
	input  wire logic [PORTS*BE_W-1:0]   port_be,
	input  wire logic [PORTS*ADDR_W-1:0] port_addr,
	input  wire logic [PORTS*DATA_W-1:0] port_wdata,
	// port answers
	output logic      [PORTS-1:0]        port_grant,
	output logic      [PORTS-1:0]        port_ready,
	output logic      [DATA_W-1:0]       port_rdata,
	output logic                         arb_done,
	// DRAM side
	output logic      [ADDR_W/2-1:0]     dram_addr,
	output logic                         dram_mux_col,
	output logic                         dram_ras_n,
	output logic      [BE_W-1:0]         dram_cas_n,
	output logic                         dram_we_n,
	input  wire logic [DATA_W-1:0]       dram_dq_in,
	output logic      [DATA_W-1:0]       dram_dq_out,
	output logic                         dram_dq_oe_n
);

	// row and column halves of a port address
	localparam int HALF = ADDR_W / 2;

	// arbiter state
	qpa_pkg::qpa_arb_t arb_q;
	qpa_pkg::qpa_arb_t arb_d;
	logic [1:0]        last_q;
	logic [1:0]        owner_q;
	logic              lock_q;
	logic              lock_d;
	logic [PORTS-1:0]  grant_q;
	logic [PORTS-1:0]  grant_d;
	logic              mem_req_q;
	logic              mem_req_d;

	// sequencer state
	qpa_pkg::qpa_seq_t seq_q;
	qpa_pkg::qpa_seq_t seq_d;
	logic [`QPA_PRE_W-1:0] pre_q;
	logic [`QPA_PRE_W-1:0] pre_d;
	logic [HALF-1:0]   col_q;
	logic [HALF-1:0]   col_d;
	logic [DATA_W-1:0] rdata_q;
	logic [PORTS-1:0]  ready_q;
	logic              done_q;
	logic [HALF-1:0]   addr_q;
	logic [HALF-1:0]   addr_d;
	logic              mux_q;
	logic              ras_n_q;
	logic [BE_W-1:0]   cas_n_q;
	logic [BE_W-1:0]   cas_n_d;
	logic              we_n_q;
	logic              oe_n_q;
	logic [DATA_W-1:0] dq_out_q;
	logic              ref_req;
	logic              ref_ack;

	// refresh request source
	qpa_refresh u_refresh (
		.clk     (clk),
		.rst_n   (rst_n),
		.ref_ack (ref_ack),
		.ref_req (ref_req)
	);

	// arbiter decode
	wire arb_idle  = (arb_q == qpa_pkg::ARB_IDLE0) || (arb_q == qpa_pkg::ARB_IDLE1) ||
	                 (arb_q == qpa_pkg::ARB_IDLE2) || (arb_q == qpa_pkg::ARB_IDLE3);
	// completion: a data beat that leads into precharge
	wire seq_done  = (seq_q == qpa_pkg::SEQ_DATA) && (seq_d == qpa_pkg::SEQ_PRE);

	// RQ18 only the locking port stays eligible
	wire [PORTS-1:0] owner_dec = PORTS'(1) << owner_q;
	wire [PORTS-1:0] eligible  = lock_q ? (port_req & owner_dec) : port_req;

	// RQ1 circular order starting after the last served port
	wire [1:0] cand1 = last_q + 2'd1;
	wire [1:0] cand2 = last_q + 2'd2;
	wire [1:0] cand3 = last_q + 2'd3;
	wire [1:0] cand4 = last_q;
	// RQ16 all four requests resolved combinationally
	wire       any_pend = |eligible;
	wire [1:0] winner   = eligible[cand1] ? cand1 :
	                      eligible[cand2] ? cand2 :
	                      eligible[cand3] ? cand3 : cand4;

	// RQ7 granted port's buses onto the shared path
	wire [1:0]        sel      = owner_q;
	wire              sel_on   = |grant_q;
	wire [ADDR_W-1:0] sel_addr = sel_on ? port_addr[sel*ADDR_W +: ADDR_W] : '0;
	wire [DATA_W-1:0] sel_wdat = sel_on ? port_wdata[sel*DATA_W +: DATA_W] : '0;
	wire [BE_W-1:0]   sel_be   = sel_on ? port_be[sel*BE_W +: BE_W] : '0;
	wire              sel_we   = sel_on & port_we[sel];
	wire              sel_bst  = sel_on & port_burst[sel];

	// arbiter next state
	always_comb begin
		arb_d     = arb_q;
		grant_d   = grant_q;
		lock_d    = lock_q & port_lock[owner_q];
		mem_req_d = mem_req_q;
		if (arb_idle) begin
			// RQ4 requests sampled only while idle
			if (any_pend) begin
				// RQ5 choose winner, raise memory request
				// RQ10 raised at once, even during precharge
				arb_d     = qpa_pkg::qpa_arb_t'({1'b1, winner});
				mem_req_d = 1'b1;
				// RQ6 grant set with the entry to active
				grant_d   = PORTS'(1) << winner;
			end
		end else begin
			// RQ8 hold until the sequencer completes
			if (seq_q == qpa_pkg::SEQ_ROW) begin
				mem_req_d = 1'b0;
			end
			if (seq_done) begin
				// RQ9 RQ2 idle of the served port
				arb_d   = qpa_pkg::qpa_arb_t'({1'b0, owner_q});
				grant_d = '0;
				// RQ3 lock held if the port keeps its lock line
				lock_d  = port_lock[owner_q];
			end
		end
	end

	// arbiter registers
	// RQ19 reset to idle, no grant, no lock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arb_q     <= qpa_pkg::ARB_IDLE3;
			last_q    <= 2'd3;
			owner_q   <= 2'd0;
			lock_q    <= 1'b0;
			grant_q   <= '0;
			mem_req_q <= 1'b0;
		end else begin
			arb_q     <= arb_d;
			lock_q    <= lock_d;
			grant_q   <= grant_d;
			mem_req_q <= mem_req_d;
			// owner taken with the grant, last served at completion
			if (arb_idle && any_pend) begin
				owner_q <= winner;
			end
			if (seq_done) begin
				last_q <= owner_q;
			end
		end
	end

	// sequencer decode
	wire start_mem = mem_req_q & sel_on;
	// RQ11 refresh first: it cannot wait, ports can
	assign ref_ack = (seq_q == qpa_pkg::SEQ_IDLE) && ref_req;
	// precharge length counted down to zero
	wire   pre_end = (pre_q == `QPA_PRE_W'(0));

	// sequencer next state
	always_comb begin
		seq_d = seq_q;
		pre_d = pre_q;
		col_d = col_q;
		unique case (seq_q)
			qpa_pkg::SEQ_IDLE: begin
				// RQ10 a new access starts only from here
				if (ref_req) begin
					seq_d = qpa_pkg::SEQ_REF_CAS;
				end else if (start_mem) begin
					seq_d = qpa_pkg::SEQ_ROW;
					col_d = sel_addr[HALF-1:0];
				end
			end
			qpa_pkg::SEQ_ROW:  seq_d = qpa_pkg::SEQ_CAS1;
			qpa_pkg::SEQ_CAS1: seq_d = qpa_pkg::SEQ_CAS2;
			qpa_pkg::SEQ_CAS2: seq_d = qpa_pkg::SEQ_DATA;
			qpa_pkg::SEQ_DATA: begin
				// RQ14 another 3-clock beat while burst held
				if (sel_bst) begin
					seq_d = qpa_pkg::SEQ_CAS1;
					col_d = col_q + HALF'(1);
				end else begin
					// RQ15 burst dropped or single: precharge
					seq_d = qpa_pkg::SEQ_PRE;
					pre_d = `QPA_PRE_W'(`QPA_TRP_CYC - 1);
				end
			end
			qpa_pkg::SEQ_REF_CAS: seq_d = qpa_pkg::SEQ_REF_RAS;
			qpa_pkg::SEQ_REF_RAS: begin
				seq_d = qpa_pkg::SEQ_PRE;
				pre_d = `QPA_PRE_W'(`QPA_TRP_CYC - 1);
			end
			qpa_pkg::SEQ_PRE: begin
				if (pre_end) begin
					seq_d = qpa_pkg::SEQ_IDLE;
				end else begin
					pre_d = pre_q - `QPA_PRE_W'(1);
				end
			end
		endcase
	end

	// RQ12 mux select and strobes from the sequencer state
	wire row_phase = (seq_d == qpa_pkg::SEQ_ROW);
	wire col_phase = (seq_d == qpa_pkg::SEQ_CAS1) || (seq_d == qpa_pkg::SEQ_CAS2);
	wire ras_on    = row_phase || col_phase || (seq_d == qpa_pkg::SEQ_DATA) ||
	                 (seq_d == qpa_pkg::SEQ_REF_RAS);
	wire ref_cas   = (seq_d == qpa_pkg::SEQ_REF_CAS) || (seq_d == qpa_pkg::SEQ_REF_RAS);
	wire [HALF-1:0] row_addr = sel_addr[ADDR_W-1:HALF];
	assign addr_d  = row_phase ? row_addr : col_d;

	// RQ12 CAS lanes gated by the port's byte selects
	always_comb begin
		cas_n_d = '1;
		if (ref_cas) begin
			cas_n_d = '0;
		end else if (col_phase) begin
			cas_n_d = ~sel_be;
		end
	end

	// RQ13 one ready per port, aligned with valid data
	wire data_beat = (seq_q == qpa_pkg::SEQ_DATA);
	logic [PORTS-1:0] ready_d;
	// each port sees only the beats of its own grant
	for (genvar i = 0; i < PORTS; i++) begin : g_ready
		assign ready_d[i] = data_beat & grant_q[i];
	end

	// sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_q <= qpa_pkg::SEQ_IDLE;
			pre_q <= '0;
			col_q <= '0;
		end else begin
			seq_q <= seq_d;
			pre_q <= pre_d;
			col_q <= col_d;
		end
	end

	// DRAM pins from flops, so strobes carry no decode glitches
	// RQ19 strobes inactive under reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q   <= '0;
			mux_q    <= 1'b0;
			ras_n_q  <= 1'b1;
			cas_n_q  <= '1;
			we_n_q   <= 1'b1;
			oe_n_q   <= 1'b1;
			dq_out_q <= '0;
		end else begin
			addr_q   <= addr_d;
			mux_q    <= col_phase;
			ras_n_q  <= ~ras_on;
			cas_n_q  <= cas_n_d;
			// RQ12 write strobe gated by port write enable
			we_n_q   <= ~(sel_we & col_phase);
			// RQ17 full 32-bit write path, enable low drives
			oe_n_q   <= ~(sel_we & (col_phase || (seq_d == qpa_pkg::SEQ_DATA)));
			// write data follows the owner; oe_n decides when it drives
			dq_out_q <= sel_wdat;
		end
	end

	// answers to ports
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
			ready_q <= '0;
			done_q  <= 1'b0;
		end else begin
			// RQ17 read captured at full width each beat
			if (data_beat && !sel_we) begin
				rdata_q <= dram_dq_in;
			end
			// RQ13 ready with the captured data
			ready_q <= ready_d;
			// RQ15 done as precharge begins
			done_q  <= seq_done;
		end
	end

	// outputs straight from their flops
	assign port_grant   = grant_q;
	assign port_ready   = ready_q;
	assign port_rdata   = rdata_q;
	assign arb_done     = done_q;
	assign dram_addr    = addr_q;
	assign dram_mux_col = mux_q;
	assign dram_ras_n   = ras_n_q;
	assign dram_cas_n   = cas_n_q;
	assign dram_we_n    = we_n_q;
	assign dram_dq_out  = dq_out_q;
	assign dram_dq_oe_n = oe_n_q;

endmodule : qpa_arbiter

// ==== qpa_arbiter_assertions.sv ====
/* checker for the quad-port arbiter port and strobe timing.
   assumes one clock domain and the default four-port widths. */
`timescale 1ns/1ns
module qpa_arbiter_assertions (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// port side
	input wire logic [3:0] port_req,
	input wire logic [3:0] port_we,
	input wire logic [3:0] port_grant,
	input wire logic [3:0] port_ready,
	input wire logic       arb_done,
	// dram side
	input wire logic       dram_mux_col,
	input wire logic       dram_ras_n,
	input wire logic [3:0] dram_cas_n,
	input wire logic       dram_dq_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// grants and strobes
	grant_onehot_a: assert property ($onehot0(port_grant))
		else $error("more than one grant");
	grant_cause_a: assert property ($rose(|port_grant) |->
		($past(port_req) & port_grant) != 4'h0) else $error("grant without request");
	reset_idle_a: assert property ($rose(rst_n) |->
		port_grant == 4'h0 && dram_ras_n && dram_cas_n == 4'hF) else $error("not idle");
	ready_owner_a: assert property (port_ready != 4'h0 |->
		port_ready == $past(port_grant)) else $error("ready to wrong port");
	done_follows_a: assert property ($fell(|port_grant) |-> ##[0:1] arb_done)
		else $error("done missing");
	// beats sit three cycles apart, never closer
	beat_gap_a: assert property (port_ready != 4'h0 |=>
		(port_ready == 4'h0) [*2]) else $error("beats too close");
	precharge_hold_a: assert property ($rose(dram_ras_n) |-> dram_ras_n [*8])
		else $error("precharge cut short");
	row_first_a: assert property ($fell(dram_ras_n) |-> !dram_mux_col)
		else $error("column on ras fall");
	drive_owner_a: assert property (!dram_dq_oe_n |->
		(port_grant & port_we) != 4'h0) else $error("dq driven without writer");

	cover property (port_ready != 4'h0 ##3 port_ready != 4'h0);
	cover property (arb_done);
	cover property ($fell(dram_ras_n) && dram_cas_n == 4'h0);
endmodule : qpa_arbiter_assertions

bind qpa_arbiter qpa_arbiter_assertions i_qpa_arbiter_assertions (
	.clk          (clk),
	.rst_n        (rst_n),
	.port_req     (port_req),
	.port_we      (port_we),
	.port_grant   (port_grant),
	.port_ready   (port_ready),
	.arb_done     (arb_done),
	.dram_mux_col (dram_mux_col),
	.dram_ras_n   (dram_ras_n),
	.dram_cas_n   (dram_cas_n),
	.dram_dq_oe_n (dram_dq_oe_n)
);

// ==== qpa_arbiter_bench.sv ====
/* self-checking bench for the quad-port arbiter with a dram model.
   assumes inputs driven at the falling edge and 250 MHz clock. */
`timescale 1ns/1ns
`define qpa_chk(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module qpa_arbiter_bench;
	logic         clk = 1'b0, rst_n = 1'b0;
	logic [3:0]   port_req = 4'h0, port_lock = 4'h0, port_burst = 4'h0, port_we = 4'h0;
	logic [15:0]  port_be = 16'hFFFF;
	logic [79:0]  port_addr = {20'h00300, 20'h00200, 20'h00100, 20'h00000};
	logic [127:0] port_wdata = 128'h0;
	logic [3:0]   port_grant, port_ready, dram_cas_n;
	logic [31:0]  port_rdata, dram_dq_in, dram_dq_out;
	logic [9:0]   dram_addr;
	logic         arb_done, dram_mux_col, dram_ras_n, dram_we_n, dram_dq_oe_n;
	int           mismatches = 0, checked = 0, last = 0;

	qpa_arbiter i_qpa_arbiter (
		.clk          (clk),
		.rst_n        (rst_n),
		.port_req     (port_req),
		.port_lock    (port_lock),
		.port_burst   (port_burst),
		.port_we      (port_we),
		.port_be      (port_be),
		.port_addr    (port_addr),
		.port_wdata   (port_wdata),
		.port_grant   (port_grant),
		.port_ready   (port_ready),
		.port_rdata   (port_rdata),
		.arb_done     (arb_done),
		.dram_addr    (dram_addr),
		.dram_mux_col (dram_mux_col),
		.dram_ras_n   (dram_ras_n),
		.dram_cas_n   (dram_cas_n),
		.dram_we_n    (dram_we_n),
		.dram_dq_in   (dram_dq_in),
		.dram_dq_out  (dram_dq_out),
		.dram_dq_oe_n (dram_dq_oe_n)
	);
	qpa_dram_model i_qpa_dram_model (
		.clk          (clk),
		.dram_addr    (dram_addr),
		.dram_mux_col (dram_mux_col),
		.dram_cas_n   (dram_cas_n),
		.dram_we_n    (dram_we_n),
		.dram_dq_out  (dram_dq_out),
		.dram_dq_in   (dram_dq_in)
	);
	always #2 clk = ~clk;

	task automatic results();
		if (mismatches == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	// bounded waits; running out ends the run
	task automatic wait_grant(output int p);
		p = -1;
		for (int n = 0; n < 300 && p < 0; n++) begin
			@(negedge clk);
			for (int i = 0; i < 4; i++) if (port_grant[i] === 1'b1) p = i;
		end
		if (p < 0) begin mismatches++; results(); end
	endtask : wait_grant

	task automatic wait_done(int nb, output int beats, output logic [31:0] rd);
		beats = 0;
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if (port_ready !== 4'h0) begin
				beats++;
				rd = port_rdata;
				if (beats >= nb - 1) port_burst = 4'h0;
			end
			if (arb_done === 1'b1) return;
		end
		mismatches++;
		results();
	endtask : wait_done

	task automatic xfer(int p, logic w, int nb, logic [31:0] d);
		int g, b;
		logic [31:0] rd;
		port_we[p] = w;
		port_burst[p] = (nb > 1);
		port_wdata[32*p +: 32] = d;
		port_req[p] = 1'b1;
		wait_grant(g);
		`qpa_chk("grant", p, g)
		port_req[p] = 1'b0;
		wait_done(nb, b, rd);
		`qpa_chk("beats", nb, b)
		if (!w) `qpa_chk("rdata", d, rd)
		last = p;
	endtask : xfer

	task automatic t_reset();
		`qpa_chk("grant", 4'h0, port_grant)
		`qpa_chk("cas", 4'hF, dram_cas_n)
		`qpa_chk("ras", 1'b1, dram_ras_n)
	endtask : t_reset

	task automatic t_single();
		xfer(0, 1'b1, 1, 32'hA5C3_0F01);
		// only lane 0 written: the other lanes keep their bytes
		port_be[3:0] = 4'h1;
		xfer(0, 1'b1, 1, 32'h5A5A_5AFF);
		port_be[3:0] = 4'hF;
		xfer(0, 1'b0, 1, 32'hA5C3_0FFF);
	endtask : t_single

	task automatic t_burst();
		xfer(1, 1'b1, 3, 32'h5A3C_F0E2);
		xfer(1, 1'b0, 3, 32'h5A3C_F0E2);
	endtask : t_burst

	// all four at once: order follows the last served port
	task automatic t_rr();
		int g, b;
		logic [31:0] rd;
		port_we = 4'h0;
		port_req = 4'hF;
		for (int k = 0; k < 4; k++) begin
			wait_grant(g);
			`qpa_chk("rr", (last + 1) % 4, g)
			port_req[g] = 1'b0;
			wait_done(1, b, rd);
			last = g;
		end
	endtask : t_rr

	task automatic t_lock();
		int g, b, p, q;
		logic [31:0] rd;
		p = (last + 1) % 4;
		q = (last + 2) % 4;
		port_lock[p] = 1'b1;
		port_req[p] = 1'b1;
		port_req[q] = 1'b1;
		wait_grant(g);
		port_req[p] = 1'b0;
		wait_done(1, b, rd);
		port_req[p] = 1'b1;
		wait_grant(g);
		`qpa_chk("lock", p, g)
		port_req[p] = 1'b0;
		port_lock[p] = 1'b0;
		wait_done(1, b, rd);
		wait_grant(g);
		`qpa_chk("unlock", q, g)
		port_req[q] = 1'b0;
		wait_done(1, b, rd);
		last = q;
	endtask : t_lock

	// reset in mid-access clears grants and strobes at once
	task automatic t_midreset();
		int g;
		port_we = 4'h0;
		port_req[2] = 1'b1;
		wait_grant(g);
		@(negedge clk);
		rst_n = 1'b0;
		port_req = 4'h0;
		@(negedge clk);
		`qpa_chk("rst_grant", 4'h0, port_grant)
		`qpa_chk("rst_strobe", 5'h1F, {dram_ras_n, dram_cas_n})
		`qpa_chk("rst_answer", 5'h00, {port_ready, arb_done})
		rst_n = 1'b1;
		last = 3;
		xfer(0, 1'b0, 1, 32'hA5C3_0FFF);
	endtask : t_midreset

	// refresh on a quiet bus: all cas lanes fall while ras is high
	task automatic t_refresh();
		int n;
		n = 0;
		while (n < 1100 && dram_cas_n !== 4'h0) begin
			@(negedge clk);
			n++;
		end
		if (n >= 1100) begin
			mismatches++;
			results();
		end
		`qpa_chk("ref_ras", 1'b1, dram_ras_n)
		@(negedge clk);
		`qpa_chk("ref_cbr", 5'h00, {dram_ras_n, dram_cas_n})
	endtask : t_refresh

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_single();
		t_burst();
		t_rr();
		t_lock();
		t_midreset();
		t_refresh();
		results();
	end
endmodule : qpa_arbiter_bench

// ==== qpa_consts.svh ====
/*
 * Constants of the quad-port DRAM arbiter: port count, widths, timing
 * figures and the cycle counts derived from them.
 * Assumes a single 250 MHz clock; included by bare name where needed.
 */
`ifndef QPA_CONSTS_SVH
`define QPA_CONSTS_SVH

// ports and widths
`define QPA_PORTS        4
`define QPA_IDX_W        2
`define QPA_DATA_W       32
`define QPA_ADDR_W       20
`define QPA_BE_W         4
`define QPA_REF_W        10

// clock rate
`define QPA_CLK_MHZ      250

// precharge least time, rounded up to whole cycles
`define QPA_TRP_NS       60
`define QPA_TRP_CYC      ((`QPA_TRP_NS * `QPA_CLK_MHZ + 999) / 1000)
`define QPA_PRE_W        4

// refresh counter reload value (full 10-bit span)
`define QPA_REF_RELOAD   10'h3FF
`define QPA_REF_ZERO     10'h000

`endif

// ==== qpa_dram_model.sv ====
/* page-mode dram model answering the arbiter's strobes.
   assumes registered strobes; one row only, rows are not kept apart;
   read data stays on the bus one cycle after cas rises. */
`timescale 1ns/1ns
module qpa_dram_model (
	// clock
	input wire logic        clk,
	// strobes and address
	input wire logic [9:0]  dram_addr,
	input wire logic        dram_mux_col,
	input wire logic [3:0]  dram_cas_n,
	input wire logic        dram_we_n,
	// data
	input wire logic [31:0] dram_dq_out,
	output logic     [31:0] dram_dq_in
);
	logic [31:0] mem [1024];
	logic [31:0] idle_q = 32'h0;
	logic [31:0] hold_q = 32'h0;
	logic        hold_v = 1'b0;
	wire         col_on = dram_mux_col && dram_cas_n != 4'hF;

	always @(posedge clk) begin
		if (col_on && !dram_we_n) begin
			for (int b = 0; b < 4; b++)
				if (!dram_cas_n[b]) mem[dram_addr][8*b +: 8] <= dram_dq_out[8*b +: 8];
		end
		// output hold: the read word outlives cas by one cycle
		hold_q <= mem[dram_addr];
		hold_v <= col_on && dram_we_n;
		idle_q <= ~dram_dq_in;
	end

	// released bus flips so stale data never looks valid
	assign dram_dq_in = (col_on && dram_we_n) ? mem[dram_addr] :
	                    hold_v ? hold_q : idle_q;
endmodule : qpa_dram_model

// ==== qpa_pkg.sv ====
/*
 * Types of the quad-port DRAM arbiter: arbiter and sequencer states.
 * Assumes qpa_consts.svh supplies the numeric constants.
 */
package qpa_pkg;

	// arbiter: four idle states, four port-active states
	typedef enum logic [2:0] {
		ARB_IDLE0,
		ARB_IDLE1,
		ARB_IDLE2,
		ARB_IDLE3,
		ARB_ACT0,
		ARB_ACT1,
		ARB_ACT2,
		ARB_ACT3
	} qpa_arb_t;

	// DRAM sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_ROW,
		SEQ_CAS1,
		SEQ_CAS2,
		SEQ_DATA,
		SEQ_REF_CAS,
		SEQ_REF_RAS,
		SEQ_PRE
	} qpa_seq_t;

endpackage : qpa_pkg

// ==== qpa_refresh.sv ====
/*
 * Refresh timer: a 10-bit down counter that raises a sticky refresh
 * request each time it wraps. Assumes the sequencer acknowledges
 * with a one-cycle pulse when it starts the refresh cycle.
 */
`timescale 1ns/1ns
`include "qpa_consts.svh"

module qpa_refresh #(
	parameter int REF_W = `QPA_REF_W
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// sequencer handshake
	input  wire logic ref_ack,
	output logic      ref_req
);

	logic [REF_W-1:0] cnt_q;
	logic [REF_W-1:0] cnt_d;
	logic             req_q;
	logic             req_d;
	wire              wrap = (cnt_q == `QPA_REF_ZERO);

	// reload on wrap, otherwise count down
	assign cnt_d = wrap ? REF_W'(`QPA_REF_RELOAD) : cnt_q - REF_W'(1);
	// a wrap in the acknowledge cycle wins, so no refresh is lost
	assign req_d = wrap | (req_q & ~ref_ack);
	assign ref_req = req_q;

	// counter and sticky request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= REF_W'(`QPA_REF_RELOAD);
			req_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			req_q <= req_d;
		end
	end

endmodule : qpa_refresh
